// [mnd_core.sv]
// executes file copy, accumulator store, literal load and no operation in one cycle each
`include "mnd_map.svh"
module mnd_core (
  input wire logic clk,
  input wire logic srst,
  input wire logic instr_valid,
  input wire logic [`MND_IW_W-1:0] instr,
  output logic [`MND_AW-1:0] file_rd_addr,
  input wire logic [`MND_DW-1:0] file_rd_data,
  output logic file_wr_en,
  output logic [`MND_AW-1:0] file_wr_addr,
  output logic [`MND_DW-1:0] file_wr_data,
  output logic [`MND_DW-1:0] accum,
  output logic zero_flag,
  output logic zero_we,
  output logic done,
  output logic unhandled
);
  import mnd_pkg::*;

  mnd_op_t op;
  logic [`MND_DW-1:0] acc_ff, nxt_acc;
  logic zero_ff, nxt_zero;
  logic zwe_ff, nxt_zwe;
  logic we_ff, nxt_we;
  logic [`MND_AW-1:0] wa_ff, nxt_wa;
  logic [`MND_DW-1:0] wd_ff, nxt_wd;
  logic done_ff, nxt_done;
  logic unh_ff, nxt_unh;
  logic [`MND_DW-1:0] src_val;

  mnd_match u_match (
    .instr(instr),
    .op(op)
  );

  // read address is combinational from the word so the file answers in the same cycle
  assign file_rd_addr = instr[`MND_AW-1:0];

  // a write launched last cycle lands in the file only at this edge;
  // forward it so a copy right behind a store does not read a stale word
  function automatic logic [`MND_DW-1:0] pick_src(
    input logic pend,
    input logic [`MND_AW-1:0] pend_addr,
    input logic [`MND_DW-1:0] pend_data,
    input logic [`MND_AW-1:0] addr,
    input logic [`MND_DW-1:0] file_data
  );
    pick_src = (pend && pend_addr == addr) ? pend_data : file_data;
  endfunction

  assign src_val = pick_src(we_ff, wa_ff, wd_ff, instr[`MND_AW-1:0], file_rd_data);

  always_comb begin
    nxt_acc = acc_ff;
    nxt_zero = zero_ff;
    nxt_zwe = 1'b0;
    nxt_we = 1'b0;
    nxt_wa = wa_ff;
    nxt_wd = wd_ff;
    nxt_done = instr_valid;
    nxt_unh = 1'b0;
    if (instr_valid) begin
      unique case (op)
        MND_OP_COPY: begin
          if (instr[`MND_DEST_BIT]) begin
            nxt_we = 1'b1;
            nxt_wa = instr[`MND_AW-1:0];
            nxt_wd = src_val;
          end else begin
            nxt_acc = src_val;
          end
          nxt_zero = (src_val == '0);
          nxt_zwe = 1'b1;
        end
        MND_OP_STORE: begin
          nxt_we = 1'b1;
          nxt_wa = instr[`MND_AW-1:0];
          nxt_wd = acc_ff;
        end
        MND_OP_LIT: begin
          nxt_acc = instr[`MND_DW-1:0];
        end
        MND_OP_NOP: begin
        end
        MND_OP_NONE: begin
          // left to the other execute units
          nxt_unh = 1'b1;
          nxt_done = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_ff <= `MND_ACC_RST;
      zero_ff <= `MND_ZERO_RST;
      zwe_ff <= 1'b0;
      we_ff <= 1'b0;
      wa_ff <= '0;
      wd_ff <= '0;
      done_ff <= 1'b0;
      unh_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      zero_ff <= nxt_zero;
      zwe_ff <= nxt_zwe;
      we_ff <= nxt_we;
      wa_ff <= nxt_wa;
      wd_ff <= nxt_wd;
      done_ff <= nxt_done;
      unh_ff <= nxt_unh;
    end
  end

  assign accum = acc_ff;
  assign zero_flag = zero_ff;
  assign zero_we = zwe_ff;
  assign file_wr_en = we_ff;
  assign file_wr_addr = wa_ff;
  assign file_wr_data = wd_ff;
  assign done = done_ff;
  assign unhandled = unh_ff;

  sequence s_copy_f;
    instr_valid && op == MND_OP_COPY && instr[`MND_DEST_BIT];
  endsequence

  sequence s_copy_a;
    instr_valid && op == MND_OP_COPY && !instr[`MND_DEST_BIT];
  endsequence

  sequence s_store;
    instr_valid && op == MND_OP_STORE;
  endsequence

  sequence s_nop;
    instr_valid && op == MND_OP_NOP;
  endsequence

  sequence s_refused;
    instr_valid && op == MND_OP_NONE;
  endsequence

  // store, then at once a copy to the accumulator of the same register
  sequence s_store_then_read;
    s_store ##1 (instr_valid && op == MND_OP_COPY && !instr[`MND_DEST_BIT]
      && instr[6:0] == $past(instr[6:0]));
  endsequence

  // file copy
  a_copy_to_file: assert property (@(posedge clk) disable iff (srst)
    s_copy_f |=> file_wr_en && file_wr_data == $past(src_val) && file_wr_addr == $past(instr[6:0])
      && $stable(accum))
    else $error("file copy write-back wrong");
  a_copy_to_acc: assert property (@(posedge clk) disable iff (srst)
    s_copy_a |=> accum == $past(src_val) && !file_wr_en)
    else $error("file copy to accumulator wrong");
  a_copy_zero: assert property (@(posedge clk) disable iff (srst)
    instr_valid && op == MND_OP_COPY |=> zero_we && zero_flag == ($past(src_val) == 8'h00))
    else $error("zero flag not set from moved value");
  a_zero_source: assert property (@(posedge clk) disable iff (srst)
    (zero_we || (!$past(srst) && !$stable(zero_flag))) |-> $past(instr_valid) && $past(op) == MND_OP_COPY)
    else $error("zero flag touched by other than a file copy");

  // accumulator store
  a_store_write: assert property (@(posedge clk) disable iff (srst)
    s_store |=> file_wr_en && file_wr_data == $past(accum) && file_wr_addr == $past(instr[6:0])
      && $stable(zero_flag) && !zero_we && $stable(accum))
    else $error("accumulator store wrong");
  a_store_forward: assert property (@(posedge clk) disable iff (srst)
    s_store_then_read |=> accum == $past(accum, 2))
    else $error("copy right after a store read a stale value");
  a_write_source: assert property (@(posedge clk) disable iff (srst)
    file_wr_en |-> $past(instr_valid)
      && ($past(op) == MND_OP_STORE || ($past(op) == MND_OP_COPY && $past(instr[7]))))
    else $error("file write without a store or write-back");
  a_write_hold: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && !file_wr_en |-> $stable(file_wr_addr) && $stable(file_wr_data))
    else $error("write address or data moved without a write");

  // literal load
  a_lit_load: assert property (@(posedge clk) disable iff (srst)
    instr_valid && instr[13:10] == 4'hC |=> accum == $past(instr[7:0]) && $stable(zero_flag) && !file_wr_en
      && !zero_we)
    else $error("literal load wrong");
  a_acc_source: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && !$stable(accum) |-> $past(instr_valid)
      && ($past(op) == MND_OP_LIT || ($past(op) == MND_OP_COPY && !$past(instr[7]))))
    else $error("accumulator changed by other than a load or copy");
  a_lit_dontcare: assert property (@(posedge clk) disable iff (srst)
    instr[13:10] == 4'hC |-> op == MND_OP_LIT)
    else $error("literal load not decoded");

  // no operation and refused words
  a_refused_quiet: assert property (@(posedge clk) disable iff (srst)
    s_refused |=> unhandled && !done && !file_wr_en && !zero_we && $stable(accum) && $stable(zero_flag))
    else $error("unhandled word changed state");
  a_nop_quiet: assert property (@(posedge clk) disable iff (srst)
    s_nop |=> !file_wr_en && !zero_we && $stable(accum) && $stable(zero_flag) && done)
    else $error("no operation changed state");
  a_nop_dontcare: assert property (@(posedge clk) disable iff (srst)
    instr[13:7] == 7'h00 && instr[4:0] == 5'h00 |-> op == MND_OP_NOP)
    else $error("no operation not decoded");
  a_idle_quiet: assert property (@(posedge clk) disable iff (srst)
    !instr_valid |=> !done && !unhandled && !file_wr_en && !zero_we && $stable(accum) && $stable(zero_flag))
    else $error("state changed with no instruction");

  // timing and reset
  a_one_cycle: assert property (@(posedge clk) disable iff (srst)
    instr_valid && op != MND_OP_NONE |=> done && !unhandled)
    else $error("instruction not finished in one cycle");
  a_done_source: assert property (@(posedge clk) disable iff (srst)
    done |-> $past(instr_valid) && $past(op) != MND_OP_NONE)
    else $error("done without a handled instruction");
  a_reset_state: assert property (@(posedge clk)
    srst |=> !done && !unhandled && !file_wr_en && !zero_we
      && accum == `MND_ACC_RST && zero_flag == `MND_ZERO_RST)
    else $error("outputs not at reset values");
endmodule

// [mnd_file_model.sv]
// register file model that answers reads in the same cycle
module mnd_file_model (
  input wire logic clk,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 3);
  assign rd_data = mem[rd_addr];
  always @(posedge clk) if (wr_en) mem[wr_addr] <= wr_data;
endmodule

// [mnd_map.svh]
// offsets, opcode patterns, reset values and timing counts for the move/no-op decoder
`ifndef MND_MAP_SVH
`define MND_MAP_SVH
`define MND_IW_W 14
`define MND_DW 8
`define MND_AW 7
`define MND_DEST_BIT 7
// file copy: 00 1000 dfff ffff
`define MND_COPY_MASK 14'h3F00
`define MND_COPY_PAT 14'h0800
// accumulator store: 00 0000 1fff ffff
`define MND_STORE_MASK 14'h3F80
`define MND_STORE_PAT 14'h0080
// literal load: 11 00xx kkkk kkkk
`define MND_LIT_MASK 14'h3C00
`define MND_LIT_PAT 14'h3000
// no operation: 00 0000 0xx0 0000
`define MND_NOP_MASK 14'h3F9F
`define MND_NOP_PAT 14'h0000
`define MND_ACC_RST 8'h00
`define MND_ZERO_RST 1'h0
`define MND_INSTR_CYCLES 1
`endif

// [mnd_match.sv]
// classifies one instruction word into the four handled operations
`include "mnd_map.svh"
module mnd_match (
  input wire logic [`MND_IW_W-1:0] instr,
  output mnd_pkg::mnd_op_t op
);
  import mnd_pkg::*;

  function automatic logic hit(input logic [`MND_IW_W-1:0] w, input logic [`MND_IW_W-1:0] m,
                               input logic [`MND_IW_W-1:0] p);
    hit = (w & m) == p;
  endfunction

  always_comb begin
    op = MND_OP_NONE;
    if (hit(instr, `MND_COPY_MASK, `MND_COPY_PAT)) begin
      op = MND_OP_COPY;
    end else if (hit(instr, `MND_STORE_MASK, `MND_STORE_PAT)) begin
      op = MND_OP_STORE;
    end else if (hit(instr, `MND_LIT_MASK, `MND_LIT_PAT)) begin
      // don't-care bits 9:8 are outside the mask
      op = MND_OP_LIT;
    end else if (hit(instr, `MND_NOP_MASK, `MND_NOP_PAT)) begin
      op = MND_OP_NOP;
    end
  end
endmodule

// [mnd_pkg.sv]
// types shared by the move/no-op decoder
package mnd_pkg;
  typedef enum logic [2:0] {
    MND_OP_NONE = 3'b000,
    MND_OP_COPY = 3'b001,
    MND_OP_STORE = 3'b010,
    MND_OP_LIT = 3'b011,
    MND_OP_NOP = 3'b100
  } mnd_op_t;
endpackage

// [move_and_nop_instr_decode_bench.sv]
// bench for the move/no-op decoder with a reference model
module move_and_nop_instr_decode_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, srst = 1, instr_valid = 0;
  logic [13:0] instr = 14'h0000;
  logic [6:0] rd_addr, wr_addr, a, e_wa;
  logic [7:0] rd_data, wr_data, accum, v, e_wd, m_acc;
  logic wr_en, zero_flag, zero_we, done, unhandled, m_z, e_we, e_zwe, e_done, e_unh;
  logic [7:0] m_mem [128];
  logic [31:0] seed = 98906, r;
  int err_count = 0, samples_checked = 0, cyc = 0, k;
  logic [13:0] dir [7] = '{14'h0880, 14'h3300, 14'h0085, 14'h0805, 14'h0060, 14'h3FFF, 14'h0009};
  logic [13:0] base [5] = '{14'h0800, 14'h0080, 14'h3000, 14'h0000, 14'h0000};
  logic [13:0] free [5] = '{14'h00FF, 14'h007F, 14'h03FF, 14'h0060, 14'h3FFF};
  mnd_core dut (.clk(clk), .srst(srst), .instr_valid(instr_valid), .instr(instr), .file_rd_addr(rd_addr),
    .file_rd_data(rd_data), .file_wr_en(wr_en), .file_wr_addr(wr_addr), .file_wr_data(wr_data),
    .accum(accum), .zero_flag(zero_flag), .zero_we(zero_we), .done(done), .unhandled(unhandled));
  mnd_file_model file_m (.clk(clk), .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      summarize();
    end
  end
  // reference model runs on the word the design samples at this edge
  always @(posedge clk) begin
    {e_we, e_zwe, e_done, e_unh} = 4'h0;
    if (srst) begin
      {m_acc, m_z, e_wa, e_wd} = 24'h000000;
    end else if (instr_valid) begin
      a = instr[6:0];
      v = m_mem[a];
      if (instr[13:8] == 6'h08) begin
        {e_done, e_zwe, m_z} = {2'h3, v == 8'h00};
        if (instr[7]) {e_we, e_wa, e_wd, m_mem[a]} = {1'b1, a, v, v};
        else m_acc = v;
      end else if (instr[13:7] == 7'h01) begin
        {e_done, e_we, e_wa, e_wd, m_mem[a]} = {2'h3, a, m_acc, m_acc};
      end else if (instr[13:10] == 4'hC) {e_done, m_acc} = {1'b1, instr[7:0]};
      else if ((instr & 14'h3F9F) == 14'h0000) e_done = 1'b1;
      else e_unh = 1'b1;
    end
  end
  // outputs have settled half a cycle after the edge
  always @(negedge clk) if (cyc > 1) begin
    check(16'({wr_en, zero_we, done}), 16'({e_we, e_zwe, e_done}));
    check(16'({unhandled, zero_flag}), 16'({e_unh, m_z}));
    check(16'(accum), 16'(m_acc));
    check(16'({wr_addr, wr_data}), 16'({e_wa, e_wd}));
    check(16'(rd_addr), 16'(instr[6:0]));
  end
  initial begin
    for (int i = 0; i < 128; i++) m_mem[i] = 8'(i * 3);
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    foreach (dir[i]) begin
      instr <= dir[i];
      instr_valid <= 1'b1;
      @(posedge clk);
    end
    $display("directed words done");
    repeat (400) begin
      r = xs();
      k = r[31:24] % 5;
      instr <= base[k] | (r[13:0] & free[k]);
      instr_valid <= r[20] | r[21];
      @(posedge clk);
    end
    instr_valid <= 1'b0;
    repeat (2) @(posedge clk);
    $display("random words done");
    summarize();
  end
endmodule
